// ===== include/intc_pkg.sv
// Constants, register map and types of the four-level interrupt controller.
package intc_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ      = 25;
  localparam int MC_CLKS      = 4;
  localparam int CALL_MC      = 4;
  localparam int LAT_MAX_MC   = 12;
  localparam int LAT_MAX_CLKS = LAT_MAX_MC * MC_CLKS;
  localparam logic [1:0] PH_C3   = 2'h2;
  localparam logic [1:0] PH_LAST = 2'h3;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int AW = 12;
  localparam logic [AW-1:0] OFS_IE_PRI   = 12'h0A8;
  localparam logic [AW-1:0] OFS_PLO_PRI  = 12'h0B8;
  localparam logic [AW-1:0] OFS_IE_EXT   = 12'h0E8;
  localparam logic [AW-1:0] OFS_PHI_PRI  = 12'h0BC;
  localparam logic [AW-1:0] OFS_PLO_EXT  = 12'h0EC;
  localparam logic [AW-1:0] OFS_PHI_EXT  = 12'h0F0;
  localparam logic [AW-1:0] OFS_CTRL     = 12'h0F4;
  localparam logic [AW-1:0] OFS_STATE    = 12'h0F8;
  localparam logic [AW-1:0] OFS_EV_STAT  = 12'h100;
  localparam logic [AW-1:0] OFS_EV_CLR   = 12'h104;
  localparam logic [AW-1:0] OFS_EV_EN    = 12'h108;
  localparam logic [7:0]    RST_REG      = 8'h00;
  localparam logic [7:0]    IE_EXT_MASK  = 8'hF7;
  localparam logic [7:0]    PRI_EXT_MASK = 8'hF3;
  localparam int            GATE_BIT     = 7;

  // ----------------------------------------------------------------------
  // Sources in polling order, highest first
  // ----------------------------------------------------------------------
  localparam int NSRC = 14;
  localparam int SRC_EXT_A = 0;
  localparam int SRC_BROWN = 1;
  localparam int SRC_WDOG  = 2;
  localparam int SRC_TMR_A = 3;
  localparam int SRC_TWI   = 4;
  localparam int SRC_CONV  = 5;
  localparam int SRC_EXT_B = 6;
  localparam int SRC_KEYP  = 7;
  localparam int SRC_TMR_B = 8;
  localparam int SRC_SER   = 9;
  localparam int SRC_BRAKE = 10;
  localparam int SRC_SPI   = 11;
  localparam int SRC_TMR_C = 12;
  localparam int SRC_CAPT  = 13;
  // Bit index into {extended, primary} enable and priority pairs.
  localparam int EN_BIT   [NSRC] = '{0, 5, 12, 1, 8, 6, 2, 9, 3, 4, 13, 14, 15, 10};
  localparam int PRIO_BIT [NSRC] = '{0, 5, 12, 1, 8, 6, 2, 9, 3, 4, 13, 14, 15, 7};
  localparam logic [15:0] VEC [NSRC] = '{16'h0003, 16'h0043, 16'h0053, 16'h000B,
    16'h0033, 16'h005B, 16'h0013, 16'h003B, 16'h001B, 16'h0023, 16'h0073,
    16'h004B, 16'h002B, 16'h0063};

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  localparam int EV_W = 3;
  localparam int EV_TAKEN  = 0;
  localparam int EV_RETURN = 1;
  localparam int EV_STRAY  = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CALL = 2'b10
  } call_state_t;

endpackage : intc_pkg

// ===== logic/phase_divider.sv
// Machine-cycle phase counter giving the clock phase, the phase-three enable and the cycle-end enable.
`timescale 1ns/1ps
`default_nettype none
module phase_divider #(
  parameter int MC_CLKS = intc_pkg::MC_CLKS
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  output logic [1:0]      phase,
  output logic            c3,
  output logic            mc_end
);
  import intc_pkg::*;

  typedef struct packed {
    logic [1:0] cnt;
  } div_t;

  div_t st_ff;
  div_t nxt_st;

  if (MC_CLKS < 3 || MC_CLKS > 4) begin : g_chk
    $error("phase_divider needs three or four clocks per machine cycle");
  end

  always_comb begin
    nxt_st = st_ff;
    if (st_ff.cnt == 2'(MC_CLKS - 1)) begin
      nxt_st.cnt = 2'h0;
    end else begin
      nxt_st.cnt = st_ff.cnt + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign phase  = st_ff.cnt;
  assign c3     = (st_ff.cnt == PH_C3);
  assign mc_end = (st_ff.cnt == 2'(MC_CLKS - 1));

endmodule : phase_divider
`default_nettype wire

// ===== logic/prio_arbiter.sv
// Four-level priority resolver with fixed polling order for ties.
`timescale 1ns/1ps
`default_nettype none
module prio_arbiter #(
  parameter int N = intc_pkg::NSRC
) (
  input  wire logic [N-1:0] req,
  input  wire logic [N-1:0] lvl_lo,
  input  wire logic [N-1:0] lvl_hi,
  output logic              found,
  output logic [3:0]        idx,
  output logic [1:0]        level
);
  import intc_pkg::*;

  if (N < 1 || N > 16) begin : g_chk
    $error("prio_arbiter serves one to sixteen sources");
  end

  // Later writes win: higher level, then lower index inside a level.
  always_comb begin
    found = 1'b0;
    idx   = 4'h0;
    level = 2'h0;
    for (int l = 0; l < 4; l++) begin
      for (int i = N - 1; i >= 0; i--) begin
        if (req[i] && ({lvl_hi[i], lvl_lo[i]} == 2'(l))) begin
          found = 1'b1;
          idx   = 4'(i);
          level = 2'(l);
        end
      end
    end
  end

endmodule : prio_arbiter
`default_nettype wire

// ===== logic/four_level_interrupt_controller.sv
// Interrupt flag sampling, gating, four-level priority and vectored call control.
`timescale 1ns/1ps
`default_nettype none
module four_level_interrupt_controller (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [intc_pkg::AW-1:0]   paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      external_input_a_n,
  input  wire logic                      external_input_b_n,
  input  wire logic                      serial_tx_flag,
  input  wire logic                      serial_rx_flag,
  input  wire logic                      timer_a_overflow,
  input  wire logic                      timer_b_overflow,
  input  wire logic                      brownout_flag,
  input  wire logic                      watchdog_flag,
  input  wire logic                      two_wire_flag,
  input  wire logic                      converter_flag,
  input  wire logic                      keypad_flag,
  input  wire logic                      brake_flag,
  input  wire logic                      spi_flag,
  input  wire logic                      timer_c_flag,
  input  wire logic                      capture_flag,
  input  wire logic                      instr_last_cycle,
  input  wire logic                      return_from_interrupt,
  output logic                           call_start,
  output logic                           call_active,
  output logic [15:0]                    call_vector,
  output logic [1:0]                     service_level,
  output logic                           irq
);
  import intc_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]      ie_pri;
    logic [7:0]      ie_ext;
    logic [7:0]      plo_pri;
    logic [7:0]      phi_pri;
    logic [7:0]      plo_ext;
    logic [7:0]      phi_ext;
    logic [1:0]      edge_mode;
    logic [NSRC-1:0] flags;
    logic [NSRC-1:0] polled;
    logic [1:0]      pin_prev;
    logic [1:0]      ovf_seen;
    logic [3:0]      in_svc;
    logic            hold;
    call_state_t     fsm;
    logic [1:0]      mc_cnt;
    logic [15:0]     vec;
    logic            pulse;
    logic [EV_W-1:0] ev_stat;
    logic [EV_W-1:0] ev_en;
    logic [31:0]     rdata;
    logic            err;
  } ctl_t;

  ctl_t st_ff;
  ctl_t nxt_st;

  logic [1:0]      phase;
  logic            c3;
  logic            mc_end;
  logic [NSRC-1:0] raw;
  logic [NSRC-1:0] en_vec;
  logic [NSRC-1:0] lo_vec;
  logic [NSRC-1:0] hi_vec;
  logic [NSRC-1:0] req;
  logic            found;
  logic [3:0]      win_idx;
  logic [1:0]      win_lvl;
  logic [1:0]      act_lvl;
  logic            any_svc;
  logic            accept;
  logic            wr;
  logic            rd_setup;
  logic            cfg_wr;
  logic [15:0]     en_all;
  logic [15:0]     lo_all;
  logic [15:0]     hi_all;

  phase_divider #(.MC_CLKS(MC_CLKS)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .phase   (phase),
    .c3      (c3),
    .mc_end  (mc_end)
  );

  // ----------------------------------------------------------------------
  // Source mapping and arbitration
  // ----------------------------------------------------------------------
  always_comb begin
    raw = '0;
    raw[SRC_EXT_A] = !external_input_a_n;
    raw[SRC_BROWN] = brownout_flag;
    raw[SRC_WDOG]  = watchdog_flag;
    raw[SRC_TWI]   = two_wire_flag;
    raw[SRC_CONV]  = converter_flag;
    raw[SRC_EXT_B] = !external_input_b_n;
    raw[SRC_KEYP]  = keypad_flag;
    raw[SRC_SER]   = serial_tx_flag | serial_rx_flag;
    raw[SRC_BRAKE] = brake_flag;
    raw[SRC_SPI]   = spi_flag;
    raw[SRC_TMR_C] = timer_c_flag;
    raw[SRC_CAPT]  = capture_flag;
  end

  assign en_all = {st_ff.ie_ext & IE_EXT_MASK, st_ff.ie_pri};
  assign lo_all = {st_ff.plo_ext & PRI_EXT_MASK, st_ff.plo_pri};
  assign hi_all = {st_ff.phi_ext & PRI_EXT_MASK, st_ff.phi_pri};

  for (genvar s = 0; s < NSRC; s++) begin : g_map
    assign en_vec[s] = (s == SRC_EXT_A || EN_BIT[s] != GATE_BIT) && en_all[EN_BIT[s]];
    assign lo_vec[s] = lo_all[PRIO_BIT[s]];
    assign hi_vec[s] = hi_all[PRIO_BIT[s]];
  end

  // The gate overrides every individual enable.
  assign req = st_ff.polled & en_vec & {NSRC{st_ff.ie_pri[GATE_BIT]}};

  prio_arbiter #(.N(NSRC)) u_arb (
    .req    (req),
    .lvl_lo (lo_vec),
    .lvl_hi (hi_vec),
    .found  (found),
    .idx    (win_idx),
    .level  (win_lvl)
  );

  always_comb begin
    act_lvl = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (st_ff.in_svc[l]) begin
        act_lvl = 2'(l);
      end
    end
  end

  assign any_svc = |st_ff.in_svc;
  // A routine at the same level blocks; only a strictly higher level gets in.
  assign accept  = (st_ff.fsm == ST_IDLE) && mc_end && instr_last_cycle && found
                   && !st_ff.hold && !cfg_wr
                   && (!any_svc || win_lvl > act_lvl);

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  assign wr       = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign cfg_wr   = wr && (paddr == OFS_IE_PRI || paddr == OFS_IE_EXT || paddr == OFS_PLO_PRI
                   || paddr == OFS_PHI_PRI || paddr == OFS_PLO_EXT || paddr == OFS_PHI_EXT);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.pulse = 1'b0;

    // Timer overflows between sampling points wait for the next phase three.
    if (!c3) begin
      nxt_st.ovf_seen = st_ff.ovf_seen | {timer_b_overflow, timer_a_overflow};
    end

    // Hardware clears edge-mode external flags and the timer A and B flags when their vector is taken.
    if (accept) begin
      if (win_idx == 4'(SRC_TMR_A) || win_idx == 4'(SRC_TMR_B)
          || (win_idx == 4'(SRC_EXT_A) && st_ff.edge_mode[0])
          || (win_idx == 4'(SRC_EXT_B) && st_ff.edge_mode[1])) begin
        nxt_st.flags[win_idx] = 1'b0;
      end
    end

    if (c3) begin
      for (int s = 0; s < NSRC; s++) begin
        if (s != SRC_TMR_A && s != SRC_TMR_B) begin
          nxt_st.flags[s] = raw[s];
        end
      end
      nxt_st.pin_prev = {external_input_b_n, external_input_a_n};
      if (st_ff.edge_mode[0]) begin
        nxt_st.flags[SRC_EXT_A] = st_ff.flags[SRC_EXT_A]
                                  | (st_ff.pin_prev[0] & !external_input_a_n);
      end
      if (st_ff.edge_mode[1]) begin
        nxt_st.flags[SRC_EXT_B] = st_ff.flags[SRC_EXT_B]
                                  | (st_ff.pin_prev[1] & !external_input_b_n);
      end
      nxt_st.flags[SRC_TMR_A] = st_ff.flags[SRC_TMR_A] | st_ff.ovf_seen[0] | timer_a_overflow;
      nxt_st.flags[SRC_TMR_B] = st_ff.flags[SRC_TMR_B] | st_ff.ovf_seen[1] | timer_b_overflow;
      nxt_st.ovf_seen = 2'h0;
    end

    // Flags set in phase three of one cycle are seen by the poll of the next.
    if (phase == PH_LAST) begin
      nxt_st.polled = nxt_st.flags;
    end

    if (mc_end && instr_last_cycle) begin
      nxt_st.hold = 1'b0;
    end
    if (cfg_wr) begin
      nxt_st.hold = 1'b1;
    end

    unique case (st_ff.fsm)
      ST_IDLE: begin
        if (accept) begin
          nxt_st.fsm    = ST_CALL;
          nxt_st.mc_cnt = 2'h0;
          nxt_st.vec    = VEC[win_idx];
          nxt_st.pulse  = 1'b1;
          nxt_st.in_svc[win_lvl] = 1'b1;
        end
      end
      ST_CALL: begin
        if (mc_end) begin
          nxt_st.mc_cnt = st_ff.mc_cnt + 2'h1;
          if (st_ff.mc_cnt == 2'(CALL_MC - 1)) begin
            nxt_st.fsm = ST_IDLE;
          end
        end
      end
    endcase

    // A plain return never reaches this port, so the routine stays in service.
    if (return_from_interrupt) begin
      if (any_svc) begin
        nxt_st.in_svc[act_lvl] = 1'b0;
      end
    end

    if (wr && paddr == OFS_EV_CLR) begin
      nxt_st.ev_stat = st_ff.ev_stat & ~pwdata[EV_W-1:0];
    end
    if (accept) begin
      nxt_st.ev_stat[EV_TAKEN] = 1'b1;
    end
    if (return_from_interrupt) begin
      nxt_st.ev_stat[EV_RETURN] = 1'b1;
      nxt_st.ev_stat[EV_STRAY]  = nxt_st.ev_stat[EV_STRAY] | !any_svc;
    end

    if (wr) begin
      unique case (paddr)
        OFS_IE_PRI:  nxt_st.ie_pri    = pwdata[7:0];
        OFS_IE_EXT:  nxt_st.ie_ext    = pwdata[7:0] & IE_EXT_MASK;
        OFS_PLO_PRI: nxt_st.plo_pri   = pwdata[7:0];
        OFS_PHI_PRI: nxt_st.phi_pri   = pwdata[7:0];
        OFS_PLO_EXT: nxt_st.plo_ext   = pwdata[7:0] & PRI_EXT_MASK;
        OFS_PHI_EXT: nxt_st.phi_ext   = pwdata[7:0] & PRI_EXT_MASK;
        OFS_CTRL:    nxt_st.edge_mode = pwdata[1:0];
        OFS_EV_EN:   nxt_st.ev_en     = pwdata[EV_W-1:0];
        default:     nxt_st.err       = st_ff.err;
      endcase
    end

    // Read data is prepared in the setup phase so the slave needs no wait state.
    if (rd_setup) begin
      nxt_st.rdata = 32'h0000_0000;
      nxt_st.err   = 1'b0;
      unique case (paddr)
        OFS_IE_PRI:  nxt_st.rdata[7:0] = st_ff.ie_pri;
        OFS_IE_EXT:  nxt_st.rdata[7:0] = st_ff.ie_ext;
        OFS_PLO_PRI: nxt_st.rdata[7:0] = st_ff.plo_pri;
        OFS_PHI_PRI: nxt_st.rdata[7:0] = st_ff.phi_pri;
        OFS_PLO_EXT: nxt_st.rdata[7:0] = st_ff.plo_ext;
        OFS_PHI_EXT: nxt_st.rdata[7:0] = st_ff.phi_ext;
        OFS_CTRL:    nxt_st.rdata[1:0] = st_ff.edge_mode;
        OFS_STATE:   nxt_st.rdata = {st_ff.vec[7:0], st_ff.flags, act_lvl, 2'h0, st_ff.hold,
                                     st_ff.fsm == ST_CALL, st_ff.in_svc};
        OFS_EV_STAT: nxt_st.rdata[EV_W-1:0] = st_ff.ev_stat;
        OFS_EV_CLR:  nxt_st.rdata = 32'h0000_0000;
        OFS_EV_EN:   nxt_st.rdata[EV_W-1:0] = st_ff.ev_en;
        default:     nxt_st.err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff         <= '0;
      st_ff.ie_pri  <= RST_REG;
      st_ff.ie_ext  <= RST_REG;
      st_ff.plo_pri <= RST_REG;
      st_ff.fsm     <= ST_IDLE;
      st_ff.pin_prev <= 2'h3;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata        = st_ff.rdata;
  assign pslverr       = st_ff.err && psel && penable;
  assign pready        = 1'b1;
  assign call_start    = st_ff.pulse;
  assign call_active   = (st_ff.fsm == ST_CALL);
  assign call_vector   = st_ff.vec;
  assign service_level = act_lvl;
  assign irq           = |(st_ff.ev_stat & st_ff.ev_en);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_FLAG_AT_C3: assert property ((!c3 && !accept) |=> $stable(st_ff.flags))
    else $error("Flags changed outside the third phase.");
  AST_TIMER_SET: assert property ((c3 && timer_a_overflow) |=> st_ff.flags[SRC_TMR_A])
    else $error("Timer A overflow flag not set at the third phase.");
  AST_POLL_LATE: assert property ($changed(st_ff.polled) |-> $past(phase) == PH_LAST)
    else $error("Polled flags changed outside the cycle boundary.");
  AST_CALL_LEN: assert property (call_start |-> call_active ##15 call_active ##1 !call_active)
    else $error("Vectored call is not four machine cycles long.");
  AST_NO_PREEMPT: assert property (call_start |-> !$past(any_svc)
      || service_level > $past(service_level))
    else $error("Request taken over an equal or higher routine.");
  AST_INSTR_END: assert property (call_start |-> $past(instr_last_cycle) && $past(mc_end))
    else $error("Vector taken away from the last cycle of an instruction.");
  AST_GATE: assert property (!st_ff.ie_pri[GATE_BIT] |=> !call_start)
    else $error("Vector taken while the global gate is clear.");
  AST_CFG_HOLD: assert property (cfg_wr |=> !call_start)
    else $error("Vector taken right after a configuration write.");
  AST_RETURN: assert property (return_from_interrupt && any_svc && !accept |=>
      $countones(st_ff.in_svc) == $countones($past(st_ff.in_svc)) - 1)
    else $error("Return did not end one routine.");
  AST_LEVEL_MARK: assert property (accept |=> st_ff.in_svc[$past(win_lvl)])
    else $error("Taken level not marked in service.");

  COV_TAKEN: cover property (call_start);
  COV_NEST: cover property (call_start && any_svc && $countones(st_ff.in_svc) > 1);
  COV_RETURN: cover property (return_from_interrupt && any_svc);
  COV_IRQ: cover property (irq);

endmodule : four_level_interrupt_controller
`default_nettype wire

// ===== verif/core_model.sv
// Behavioural processor core that turns ret_now requests into one-clock return pulses.
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow,
  input  wire logic ret_now,
  output logic      instr_last_cycle,
  output logic      return_from_interrupt
);
  logic [4:0] clk_cnt;
  logic       ret_q;

  // A slow instruction spans five machine cycles, so a vector is taken only in its last one.
  assign instr_last_cycle = !slow || (clk_cnt >= 5'h10);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_cnt               <= 5'h00;
      ret_q                 <= 1'b0;
      return_from_interrupt <= 1'b0;
    end else begin
      clk_cnt               <= (clk_cnt == 5'h13) ? 5'h00 : clk_cnt + 5'h01;
      ret_q                 <= ret_now;
      return_from_interrupt <= ret_now && !ret_q;
    end
  end
endmodule : core_model
`default_nettype wire

// ===== verif/four_level_interrupt_controller_tb.sv
// Self-checking bench for the four-level interrupt controller.
`timescale 1ns/1ps
`default_nettype none
module four_level_interrupt_controller_tb;
  import intc_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic          slow, ret_now, rx, instr_last_cycle, return_from_interrupt;
  logic          call_start, call_active, irq;
  logic [AW-1:0] paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic [15:0]   call_vector;
  logic [13:0]   flg;
  logic [1:0]    service_level;
  int            mismatches, checks, cycles, lat;

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  four_level_interrupt_controller dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .external_input_a_n(~flg[0]), .external_input_b_n(~flg[6]), .serial_tx_flag(flg[9]),
    .serial_rx_flag(rx), .timer_a_overflow(flg[3]), .timer_b_overflow(flg[8]),
    .brownout_flag(flg[1]), .watchdog_flag(flg[2]), .two_wire_flag(flg[4]),
    .converter_flag(flg[5]), .keypad_flag(flg[7]), .brake_flag(flg[10]), .spi_flag(flg[11]),
    .timer_c_flag(flg[12]), .capture_flag(flg[13]), .instr_last_cycle, .return_from_interrupt,
    .call_start, .call_active, .call_vector, .service_level, .irq
  );

  core_model core (.pclk, .presetn, .slow, .ret_now, .instr_last_cycle, .return_from_interrupt);

  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic put(input logic [14:0] v);
    @(posedge pclk);
    {rx, flg} <= v;
  endtask : put

  task automatic want_call(input logic [15:0] vec);
    lat = 0;
    do begin
      @(negedge pclk);
      lat++;
    end while (call_start !== 1'b1 && lat < 200);
    chk(32'(call_start), 32'h1);
    chk(32'(call_active), 32'h1);
    chk(32'(call_vector), 32'(vec));
  endtask : want_call

  task automatic want_none(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge pclk);
      seen |= (call_start !== 1'b0);
    end
    chk(32'(seen), 32'h0);
  endtask : want_none

  // The core only returns once the call sequence itself has finished.
  task automatic ret();
    while (call_active !== 1'b0) @(negedge pclk);
    @(posedge pclk);
    ret_now <= 1'b1;
    @(posedge pclk);
    ret_now <= 1'b0;
  endtask : ret

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    flg     = '0;
    rx      = 1'b0;
    slow    = 1'b0;
    ret_now = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_IE_PRI, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_PLO_PRI, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_IE_EXT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0C0, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, OFS_IE_EXT, 32'hFF);
    apb(1'b0, OFS_IE_EXT, 32'h0);
    chk(rd, 32'hF7);
    apb(1'b1, OFS_IE_PRI, 32'h7F);
    put(14'h0002);
    want_none(60);
    apb(1'b1, OFS_IE_PRI, 32'hFF);
    want_call(VEC[1]);
    put(14'h0000);
    ret();
    // The serial source is driven from its receive input only; the transmit input stays low.
    for (int i = 0; i < NSRC; i++) begin
      slow <= i[0];
      put(i == 9 ? 15'h4000 : 15'h0001 << i);
      if (i == 3 || i == 8) put(14'h0000);
      want_call(VEC[i]);
      chk(32'(lat + 16 <= LAT_MAX_CLKS), 32'h1);
      chk(32'(lat > MC_CLKS), 32'h1);
      put(14'h0000);
      ret();
    end
    slow <= 1'b0;
    put(14'h0006);
    want_call(VEC[1]);
    put(14'h0004);
    want_none(60);
    ret();
    want_call(VEC[2]);
    put(14'h0000);
    ret();
    apb(1'b1, OFS_PLO_PRI, 32'h20);
    put(14'h0001);
    want_call(VEC[0]);
    put(14'h0002);
    want_call(VEC[1]);
    chk(32'(service_level), 32'h1);
    put(14'h0000);
    ret();
    ret();
    repeat (3) @(negedge pclk);
    chk(32'(service_level), 32'h0);
    // Edge mode: a pin held low after the call must not vector a second time.
    apb(1'b1, OFS_PHI_PRI, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h1);
    put(14'h0001);
    want_call(VEC[0]);
    chk(32'(service_level), 32'h2);
    ret();
    want_none(60);
    put(14'h0000);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_EV_CLR, 32'h7);
    apb(1'b1, OFS_EV_EN, 32'h4);
    ret();
    repeat (3) @(negedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b0, OFS_EV_STAT, 32'h0);
    chk(rd, 32'h6);
    apb(1'b1, OFS_EV_EN, 32'h0);
    @(negedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b1, OFS_EV_CLR, 32'h4);
    apb(1'b0, OFS_EV_STAT, 32'h0);
    chk(rd, 32'h2);
    tally_and_finish();
  end
endmodule : four_level_interrupt_controller_tb
`default_nettype wire
